/* include/lrd_defines.vh */
// Constants for the receive lane deserializer: register map, fields, reset values
`ifndef LRD_DEFINES_VH
`define LRD_DEFINES_VH

// Register bus geometry
`define LRD_ADDR_W 4
`define LRD_DATA_W 32

// Register indices on the plain register port
`define LRD_ADDR_CTRL 4'h0
`define LRD_ADDR_STATUS 4'h1
`define LRD_ADDR_WCOUNT 4'h2
`define LRD_ADDR_LIVE 4'h3

// Control register fields
`define LRD_CTRL_DESER_EN 0
`define LRD_CTRL_CONN_ALT 1
`define LRD_CTRL_ODT_EN 2
`define LRD_CTRL_WIDTH_LSB 4
`define LRD_CTRL_WIDTH_MSB 7

// Control reset values
`define LRD_RST_DESER_EN 1'b1
`define LRD_RST_CONN_ALT 1'b0
`define LRD_RST_ODT_EN 1'b0
`define LRD_RST_WIDTH 4'h8

// Allowed deserialization factors
`define LRD_WIDTH_MIN 4'h2
`define LRD_WIDTH_MAX 4'h8

// Status register fields
`define LRD_STAT_WORD_LSB 0
`define LRD_STAT_WORD_MSB 7
`define LRD_STAT_MISALIGN 8
`define LRD_STAT_PAD_FAULT 9

// Synchroniser depth for pins and foreign clocks
`define LRD_SYNC_STAGES 2

`endif

/* verilog/lrd_sync.v */
// Two-flop synchroniser bank for pins and foreign clocks
`timescale 1ns/1ps
module lrd_sync #(
  parameter WIDTH = 4
) (
  input wire clk,
  input wire reset_n,
  input wire ce,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      reg meta_r;
      reg stable_r;
      // First stage feeds only the second stage
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          meta_r <= 1'b0;
          stable_r <= 1'b0;
        end else if (ce) begin
          meta_r <= async_in[gi];
          stable_r <= meta_r;
        end
      end
      assign sync_out[gi] = stable_r;
    end
  endgenerate

endmodule // lrd_sync

/* verilog/lrd_rx_deser.v */
// Receive lane deserializer with bypass, alternate clock path and register port
//
// Behaviour
// - Word is n bits; a width of one is refused
// - Side output only in bypass with alternate type
// - Bit-rate clock shifts serial pad data in
// - Word-rate clock captures assembled word
// - Word not aligned, handed over on word-clock rise even if partial
// - Connection type picks normal or PLL clock input
// - Deserialization off bypasses to plain input
// - Width accepts factors two through eight
// - Termination switched across pads when enabled
`timescale 1ns/1ps
`include "lrd_defines.vh"
module lrd_rx_deser #(
  parameter MAX_W = 8
) (
  input wire clk,
  input wire reset_n,
  input wire ce,
  input wire positive_rx_pad,
  input wire negative_rx_pad,
  input wire bit_rate_clock,
  input wire word_rate_clock,
  input wire [`LRD_ADDR_W-1:0] reg_addr,
  input wire [`LRD_DATA_W-1:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [`LRD_DATA_W-1:0] reg_rdata,
  output reg [MAX_W-1:0] rx_word,
  output reg rx_word_valid,
  output reg bypass_side_output,
  output reg odt_enable
);

  // Pins and the two lane clocks come from outside this domain
  wire [3:0] sync_w;
  lrd_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .async_in({word_rate_clock, bit_rate_clock, negative_rx_pad, positive_rx_pad}),
    .sync_out(sync_w)
  );

  wire pad_p = sync_w[0];
  wire pad_n = sync_w[1];
  wire bclk_s = sync_w[2];
  wire wclk_s = sync_w[3];

  // Control state
  reg deser_en_r;
  reg conn_alt_r;
  reg odt_en_r;
  reg [3:0] width_r;

  // Datapath state
  reg bclk_d_r;
  reg wclk_d_r;
  reg [MAX_W-1:0] shift_r;
  reg [MAX_W-1:0] shift_nxt;
  reg [3:0] bit_cnt_r;
  reg [3:0] bit_cnt_nxt;
  reg [MAX_W-1:0] last_word_r;
  reg misalign_r;
  reg pad_fault_r;
  reg [15:0] wcount_r;
  reg pad_bit_r;

  wire bypass = !deser_en_r;
  wire bit_rise = bclk_s & ~bclk_d_r;
  wire word_rise = wclk_s & ~wclk_d_r;
  wire pad_bit = (pad_p != pad_n) ? pad_p : pad_bit_r;
  wire [3:0] width_wr = reg_wdata[`LRD_CTRL_WIDTH_MSB:`LRD_CTRL_WIDTH_LSB];
  wire width_ok = (width_wr >= `LRD_WIDTH_MIN) && (width_wr <= `LRD_WIDTH_MAX);
  wire wr_ctrl = reg_write && (reg_addr == `LRD_ADDR_CTRL);
  wire wr_stat = reg_write && (reg_addr == `LRD_ADDR_STATUS);

  // Mask that keeps only the n lowest bits of a word
  reg [MAX_W-1:0] width_mask;
  integer mi;
  always @* begin
    width_mask = {MAX_W{1'b0}};
    for (mi = 0; mi < MAX_W; mi = mi + 1) begin
      if (mi < width_r) begin
        width_mask[mi] = 1'b1;
      end
    end
  end

  // Software-written configuration
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      deser_en_r <= `LRD_RST_DESER_EN;
      conn_alt_r <= `LRD_RST_CONN_ALT;
      odt_en_r <= `LRD_RST_ODT_EN;
      width_r <= `LRD_RST_WIDTH;
    end else if (ce && wr_ctrl) begin
      deser_en_r <= reg_wdata[`LRD_CTRL_DESER_EN];
      conn_alt_r <= reg_wdata[`LRD_CTRL_CONN_ALT];
      odt_en_r <= reg_wdata[`LRD_CTRL_ODT_EN];
      // Out of range factors are ignored so the shifter never sees zero
      if (width_ok) begin
        width_r <= width_wr;
      end
    end
  end

  // Next shift contents; a word edge may coincide with a bit edge
  always @* begin
    shift_nxt = shift_r;
    bit_cnt_nxt = bit_cnt_r;
    if (bit_rise) begin
      // Newest bit lands in bit zero, oldest climbs toward n-1
      shift_nxt = {shift_r[MAX_W-2:0], pad_bit};
      bit_cnt_nxt = bit_cnt_r + 4'h1;
    end
    if (word_rise) begin
      // Coincident bit closes this word, so the next word starts empty
      bit_cnt_nxt = 4'h0;
    end
  end

  // Edge history and serial shifter
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bclk_d_r <= 1'b0;
      wclk_d_r <= 1'b0;
      shift_r <= {MAX_W{1'b0}};
      bit_cnt_r <= 4'h0;
      pad_bit_r <= 1'b0;
    end else if (ce) begin
      bclk_d_r <= bclk_s;
      wclk_d_r <= wclk_s;
      pad_bit_r <= pad_bit;
      if (!bypass) begin
        shift_r <= shift_nxt;
        bit_cnt_r <= bit_cnt_nxt;
      end else begin
        bit_cnt_r <= 4'h0;
      end
    end
  end

  // Word capture and the parallel output toward the core
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_word <= {MAX_W{1'b0}};
      rx_word_valid <= 1'b0;
      last_word_r <= {MAX_W{1'b0}};
      wcount_r <= 16'h0000;
    end else if (ce) begin
      rx_word_valid <= 1'b0;
      if (bypass) begin
        // Plain input: bit zero follows the pad, held at zero with the alternate type, no lane clock involved
        rx_word <= {{(MAX_W-1){1'b0}}, (conn_alt_r ? 1'b0 : pad_bit)};
      end else if (word_rise) begin
        // Word taken at the word-clock rise even if partial; misalignment is flagged separately
        rx_word <= shift_nxt & width_mask;
        last_word_r <= shift_nxt & width_mask;
        rx_word_valid <= 1'b1;
        wcount_r <= wcount_r + 16'h0001;
      end
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  wire [3:0] bits_seen = bit_cnt_r + (bit_rise ? 4'h1 : 4'h0);
  wire misalign_evt = !bypass && word_rise && (bits_seen != width_r);
  // Both pad legs read zero until the synchroniser fills, so wait before judging
  localparam [1:0] PRIME_LEN = `LRD_SYNC_STAGES;
  reg [1:0] prime_r;
  wire primed = (prime_r == PRIME_LEN);
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prime_r <= 2'h0;
    end else if (ce && !primed) begin
      prime_r <= prime_r + 2'h1;
    end
  end
  wire pad_fault_evt = primed && (pad_p == pad_n);
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      misalign_r <= 1'b0;
      pad_fault_r <= 1'b0;
    end else if (ce) begin
      if (misalign_evt) begin
        misalign_r <= 1'b1;
      end else if (wr_stat && reg_wdata[`LRD_STAT_MISALIGN]) begin
        misalign_r <= 1'b0;
      end
      if (pad_fault_evt) begin
        pad_fault_r <= 1'b1;
      end else if (wr_stat && reg_wdata[`LRD_STAT_PAD_FAULT]) begin
        pad_fault_r <= 1'b0;
      end
    end
  end

  // Alternate path and termination drive, both registered
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bypass_side_output <= 1'b0;
      odt_enable <= 1'b0;
    end else if (ce) begin
      // Only live in bypass with the PLL-clock connection type
      bypass_side_output <= bypass && conn_alt_r && pad_bit;
      odt_enable <= odt_en_r;
    end
  end

  // Read data for the cycle after the strobe; unmapped reads give zero
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h00000000;
    end else if (ce) begin
      reg_rdata <= 32'h00000000;
      if (reg_read) begin
        case (reg_addr)
          `LRD_ADDR_CTRL: begin
            reg_rdata[`LRD_CTRL_DESER_EN] <= deser_en_r;
            reg_rdata[`LRD_CTRL_CONN_ALT] <= conn_alt_r;
            reg_rdata[`LRD_CTRL_ODT_EN] <= odt_en_r;
            reg_rdata[`LRD_CTRL_WIDTH_MSB:`LRD_CTRL_WIDTH_LSB] <= width_r;
          end
          `LRD_ADDR_STATUS: begin
            reg_rdata[`LRD_STAT_WORD_MSB:`LRD_STAT_WORD_LSB] <= last_word_r;
            reg_rdata[`LRD_STAT_MISALIGN] <= misalign_r;
            reg_rdata[`LRD_STAT_PAD_FAULT] <= pad_fault_r;
          end
          `LRD_ADDR_WCOUNT: begin
            reg_rdata[15:0] <= wcount_r;
          end
          `LRD_ADDR_LIVE: begin
            reg_rdata[MAX_W-1:0] <= shift_r;
            reg_rdata[11:8] <= bit_cnt_r;
          end
          default: begin
            reg_rdata <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule // lrd_rx_deser

/* test/lrd_rx_deser_monitor.sv */
// Port checker for the receive lane deserializer
`timescale 1ns/1ps
`include "lrd_defines.vh"
module lrd_rx_deser_monitor #(
  parameter MAX_W = 8
) (
  input wire clk,
  input wire reset_n,
  input wire ce,
  input wire positive_rx_pad,
  input wire negative_rx_pad,
  input wire bit_rate_clock,
  input wire word_rate_clock,
  input wire [`LRD_ADDR_W-1:0] reg_addr,
  input wire [`LRD_DATA_W-1:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [`LRD_DATA_W-1:0] reg_rdata,
  input wire [MAX_W-1:0] rx_word,
  input wire rx_word_valid,
  input wire bypass_side_output,
  input wire odt_enable
);
  reg [7:0] ctl_r;
  reg [2:0] quiet_r;
  wire settled = quiet_r == 3'h7;
  wire byp = settled && !ctl_r[0];
  // Control mirror; quiet count hides the pad pipeline after a change
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_r <= 8'h81;
      quiet_r <= 3'h0;
    end else if (ce && reg_write && reg_addr == `LRD_ADDR_CTRL) begin
      ctl_r[2:0] <= reg_wdata[2:0];
      if (reg_wdata[7:4] >= 4'h2 && reg_wdata[7:4] <= 4'h8)
        ctl_r[7:4] <= reg_wdata[7:4];
      quiet_r <= 3'h0;
    end else if (!settled) begin
      quiet_r <= quiet_r + 3'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_rise; $rose(word_rate_clock) && settled && ctl_r[0] && ce; endsequence
  property p_rise; s_rise |-> ##[2:6] rx_word_valid; endproperty
  a_rise: assert property (p_rise) else $error("word rise not captured");
  property p_pulse; rx_word_valid |=> !rx_word_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("valid too long");
  property p_width; rx_word_valid && settled |-> (rx_word >> ctl_r[7:4]) == 0; endproperty
  a_width: assert property (p_width) else $error("bits above width");
  property p_byp; byp |-> rx_word[MAX_W-1:1] == 0 && !rx_word_valid; endproperty
  a_byp: assert property (p_byp) else $error("bypass word wrong");
  property p_alt; byp && ctl_r[1] |-> rx_word == 0; endproperty
  a_alt: assert property (p_alt) else $error("alt lane drives word");
  property p_side; settled && !(byp && ctl_r[1]) |-> !bypass_side_output; endproperty
  a_side: assert property (p_side) else $error("side output active");
  property p_odt; settled |-> odt_enable == ctl_r[2]; endproperty
  a_odt: assert property (p_odt) else $error("termination wrong");
  property p_idle; !reg_read && ce |=> reg_rdata == 0; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
endmodule // lrd_rx_deser_monitor
bind lrd_rx_deser lrd_rx_deser_monitor #(
  .MAX_W(MAX_W)
) u_mon (
  .clk(clk),
  .reset_n(reset_n),
  .ce(ce),
  .positive_rx_pad(positive_rx_pad),
  .negative_rx_pad(negative_rx_pad),
  .bit_rate_clock(bit_rate_clock),
  .word_rate_clock(word_rate_clock),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_write(reg_write),
  .reg_read(reg_read),
  .reg_rdata(reg_rdata),
  .rx_word(rx_word),
  .rx_word_valid(rx_word_valid),
  .bypass_side_output(bypass_side_output),
  .odt_enable(odt_enable)
);

/* test/lrd_tx_model.sv */
// Behavioural serial transmitter on the receive pads
`timescale 1ns/1ps
module lrd_tx_model (
  output reg positive_rx_pad,
  output reg negative_rx_pad,
  output reg bit_rate_clock,
  output reg word_rate_clock
);
  initial begin
    positive_rx_pad = 1'b0;
    negative_rx_pad = 1'b1;
    bit_rate_clock = 1'b0;
    word_rate_clock = 1'b0;
  end
  // Plain level; pads always opposite
  task level(input v);
    begin
      positive_rx_pad = v;
      negative_rx_pad = !v;
    end
  endtask
  // Oldest bit first; offset keeps edges off the system clock
  task send(input [7:0] w, input integer n, input integer half);
    integer i;
    begin
      #3;
      for (i = n - 1; i >= 0; i = i - 1) begin
        level(w[i]);
        #half;
        bit_rate_clock = 1'b1;
        word_rate_clock = (i == 0);
        #half;
        bit_rate_clock = 1'b0;
      end
      word_rate_clock = 1'b0;
      level(!positive_rx_pad);
    end
  endtask
endmodule // lrd_tx_model

/* test/testbench.sv */
// Self-checking bench for the receive lane deserializer
`timescale 1ns/1ps
module testbench;
  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg ce = 1'b1;
  reg [3:0] reg_addr = 4'h0;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_write = 1'b0;
  reg reg_read = 1'b0;
  reg rd_d = 1'b0;
  wire [31:0] reg_rdata;
  wire [7:0] rx_word;
  wire rx_word_valid, bypass_side_output, odt_enable;
  wire positive_rx_pad, negative_rx_pad, bit_rate_clock, word_rate_clock;
  logic [7:0] wq[$];
  logic [31:0] rq[$];
  logic [7:0] d;
  integer miscompares = 0, n_checks = 0, cyc = 0, w;
  lrd_rx_deser #(
    .MAX_W(8)
  ) u_dut (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .positive_rx_pad(positive_rx_pad),
    .negative_rx_pad(negative_rx_pad),
    .bit_rate_clock(bit_rate_clock),
    .word_rate_clock(word_rate_clock),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .rx_word(rx_word),
    .rx_word_valid(rx_word_valid),
    .bypass_side_output(bypass_side_output),
    .odt_enable(odt_enable)
  );
  lrd_tx_model u_tx (
    .positive_rx_pad(positive_rx_pad),
    .negative_rx_pad(negative_rx_pad),
    .bit_rate_clock(bit_rate_clock),
    .word_rate_clock(word_rate_clock)
  );
  always #10 clk = ~clk;
  task end_sim;
    begin
      if (miscompares == 0 && n_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("wrong value %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] v);
    begin
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input [3:0] a, input [31:0] e);
    begin
      rq.push_back(e);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      @(posedge clk);
    end
  endtask
  task word(input integer n, input integer half, input [7:0] v);
    begin
      wq.push_back(v);
      u_tx.send(v, n, half);
      repeat (8) @(posedge clk);
    end
  endtask
  task pad(input v);
    begin
      #3;
      u_tx.level(v);
      repeat (6) @(posedge clk);
    end
  endtask
  // Results are matched against the oldest note when they appear
  always @(posedge clk) begin
    rd_d <= reg_read;
    if (rd_d)
      chk("reg_rdata", rq.pop_front(), reg_rdata);
    if (rx_word_valid === 1'b1)
      chk("rx_word", wq.size() ? wq.pop_front() : 8'hxx, rx_word);
  end
  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      end_sim;
    end
  end
  initial begin
    d = $urandom(37306);
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(4'h0, 32'h81);
    rd(4'hf, 32'h0);
    rd(4'h3, 32'h0);
    // Strobe while frozen must leave control untouched
    ce <= 1'b0;
    wr(4'h0, 32'h0);
    ce <= 1'b1;
    rd(4'h0, 32'h81);
    for (w = 2; w <= 8; w++) begin
      wr(4'h0, {w[3:0], 1'b0, w[0], 2'b01});
      d = $urandom_range(0, (1 << w) - 1);
      word(w, w[0] ? 130 : 50, d);
      chk("odt_enable", w[0], odt_enable);
    end
    wr(4'h0, 32'h91);
    rd(4'h0, 32'h81);
    word(8, 50, 8'ha5);
    wr(4'h0, 32'h23);
    word(2, 50, 8'h02);
    // Last word kept, no alignment or pad fault, one count per word
    rd(4'h1, 32'h2);
    rd(4'h2, 32'h9);
    // Plain input, then the alternate clock path; lane clocks stay idle
    for (w = 0; w < 4; w++) begin
      if (!w[0])
        wr(4'h0, {6'h20, w[1], 1'b0});
      pad(w[0]);
      chk("rx_word", w[0] & !w[1], rx_word);
      chk("side_output", w[0] & w[1], bypass_side_output);
    end
    chk("words_left", 0, wq.size());
    end_sim;
  end
endmodule // testbench
